// ==== design/cpet_timer.sv ====
// Timer block with PWM, event counting and dual capture
`timescale 1ns/100ps
module cpet_timer
  import cpet_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [3:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  input wire logic timer_pin_a_i,
  output logic timer_pin_a_o,
  output logic timer_pin_a_oe_o,
  input wire logic timer_pin_b_i,
  output logic irq_a_o,
  output logic irq_b_o
);
  typedef struct packed {
    logic [15:0] count;
    logic [15:0] reg_a;
    logic [15:0] reg_b;
    logic run_or_underflow_bit;
    logic mode_sel_bit1;
    logic mode_sel_bit2;
    logic mode_sel_bit3;
    logic pending_flag_a;
    logic pending_flag_b;
    logic irq_enable_a;
    logic irq_enable_b;
    logic next_is_b;
    logic pin_a;
    logic pin_oe;
    logic irq_a;
    logic irq_b;
    logic ack;
    logic [31:0] dat;
    logic [5:0] div;
  } cpet_state_s;

  cpet_state_s q, d;

  logic a_rise, a_fall, b_rise, b_fall;
  logic tick, cap_mode, pwm_mode, evt_mode;
  logic dec, uflow, edge_a, edge_b;
  logic set_a, set_b, set_run;
  logic req, wr, wr_ctrl, wr_cnt, wr_ra, wr_rb;
  logic [7:0] ctrl_rd;

  cpet_pin_sync u_sync_a (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .pin_i(timer_pin_a_i),
    .rise_o(a_rise),
    .fall_o(a_fall)
  );

  cpet_pin_sync u_sync_b (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .pin_i(timer_pin_b_i),
    .rise_o(b_rise),
    .fall_o(b_fall)
  );

  always_comb begin
    d = q;
    set_a = 1'b0;
    set_b = 1'b0;
    set_run = 1'b0;
    ctrl_rd = {q.mode_sel_bit3, q.mode_sel_bit2, q.mode_sel_bit1,
               q.run_or_underflow_bit, q.pending_flag_a, q.irq_enable_a,
               q.pending_flag_b, q.irq_enable_b};

    // Instruction cycle enable from the system clock
    tick = (q.div == TC_LAST);
    d.div = tick ? '0 : q.div + DIV_ONE;

    cap_mode = q.mode_sel_bit2;
    pwm_mode = !q.mode_sel_bit2 && q.mode_sel_bit3;
    evt_mode = !q.mode_sel_bit2 && !q.mode_sel_bit3;

    // Capture runs free; other modes obey the run bit
    if (cap_mode) begin
      dec = tick;
    end else if (pwm_mode) begin
      dec = q.run_or_underflow_bit && tick;
    end else begin
      dec = q.run_or_underflow_bit
            && (q.mode_sel_bit1 ? a_fall : a_rise);
    end
    uflow = dec && (q.count == CNT_ZERO);
    if (dec) begin
      d.count = q.count - CNT_ONE;
    end

    if (uflow) begin
      if (cap_mode) begin
        d.count = CNT_WRAP;
        set_run = 1'b1;
      end else if (pwm_mode) begin
        d.count = q.next_is_b ? q.reg_b : q.reg_a;
        set_a = !q.next_is_b;
        set_b = q.next_is_b;
        d.next_is_b = !q.next_is_b;
        if (q.mode_sel_bit1) begin
          d.pin_a = !q.pin_a;
        end
      end else begin
        // Event counter restarts its period from register A
        d.count = q.reg_a;
        set_a = 1'b1;
      end
    end
    // A restart always begins with a register A reload
    if (!pwm_mode || !q.run_or_underflow_bit) begin
      d.next_is_b = 1'b0;
    end
    d.pin_oe = pwm_mode && q.mode_sel_bit1;

    edge_a = q.mode_sel_bit1 ? a_fall : a_rise;
    edge_b = q.mode_sel_bit3 ? b_fall : b_rise;
    if (cap_mode && edge_a) begin
      d.reg_a = q.count;
      set_a = 1'b1;
    end
    if (cap_mode && edge_b) begin
      d.reg_b = q.count;
      set_b = 1'b1;
    end
    if (evt_mode && b_rise) begin
      set_b = 1'b1;
    end

    // Registered-ack slave; ack comes one cycle after the request, write lands with ack
    req = cyc_i && stb_i;
    d.ack = req && !q.ack;
    wr = req && we_i && q.ack;
    wr_ctrl = wr && (adr_i == ADR_CTRL) && sel_i[0];
    wr_cnt = wr && (adr_i == ADR_COUNT);
    wr_ra = wr && (adr_i == ADR_REG_A);
    wr_rb = wr && (adr_i == ADR_REG_B);
    if (wr_cnt) begin
      if (sel_i[0]) d.count[7:0] = dat_i[7:0];
      if (sel_i[1]) d.count[15:8] = dat_i[15:8];
    end
    if (wr_ra) begin
      if (sel_i[0]) d.reg_a[7:0] = dat_i[7:0];
      if (sel_i[1]) d.reg_a[15:8] = dat_i[15:8];
    end
    if (wr_rb) begin
      if (sel_i[0]) d.reg_b[7:0] = dat_i[7:0];
      if (sel_i[1]) d.reg_b[15:8] = dat_i[15:8];
    end
    if (wr_ctrl) begin
      d.irq_enable_b = dat_i[B_ENB];
      d.pending_flag_b = dat_i[B_PNDB];
      d.irq_enable_a = dat_i[B_ENA];
      d.pending_flag_a = dat_i[B_PNDA];
      d.run_or_underflow_bit = dat_i[B_RUN];
      d.mode_sel_bit1 = dat_i[B_M1];
      d.mode_sel_bit2 = dat_i[B_M2];
      d.mode_sel_bit3 = dat_i[B_M3];
    end
    // Hardware set wins over a software clear in the same cycle
    d.pending_flag_a = d.pending_flag_a || set_a;
    d.pending_flag_b = d.pending_flag_b || set_b;
    d.run_or_underflow_bit = d.run_or_underflow_bit || set_run;

    if (req && !q.ack && !we_i) begin
      unique case (adr_i)
        ADR_CTRL: d.dat = {24'h000000, ctrl_rd};
        ADR_COUNT: d.dat = {16'h0000, q.count};
        ADR_REG_A: d.dat = {16'h0000, q.reg_a};
        ADR_REG_B: d.dat = {16'h0000, q.reg_b};
        default: d.dat = 32'h00000000;
      endcase
    end

    d.irq_a = q.irq_enable_a && (q.pending_flag_a
              || (cap_mode && q.run_or_underflow_bit));
    d.irq_b = q.irq_enable_b && q.pending_flag_b;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  // Same module per instance; bench instantiates one
  assign dat_o = q.dat;
  assign ack_o = q.ack;
  assign timer_pin_a_o = q.pin_a;
  assign timer_pin_a_oe_o = q.pin_oe;
  assign irq_a_o = q.irq_a;
  assign irq_b_o = q.irq_b;

  property p_capture_a;
    @(posedge clk_i) disable iff (rst_i)
    cap_mode && edge_a && !wr_ra |=> q.reg_a == $past(q.count);
  endproperty
  a_capture_a: assert property (p_capture_a)
    else $error("register A missed capture");

  property p_capture_b;
    @(posedge clk_i) disable iff (rst_i)
    cap_mode && edge_b && !wr_rb |=> q.reg_b == $past(q.count)
      && q.pending_flag_b;
  endproperty
  a_capture_b: assert property (p_capture_b)
    else $error("register B missed capture");

  property p_wrap;
    @(posedge clk_i) disable iff (rst_i)
    cap_mode && uflow && !wr_cnt |=> q.count == CNT_WRAP
      && q.run_or_underflow_bit;
  endproperty
  a_wrap: assert property (p_wrap)
    else $error("capture underflow wrong");

  property p_pwm_order;
    @(posedge clk_i) disable iff (rst_i)
    pwm_mode && uflow && !q.next_is_b && !wr_cnt
      |=> q.count == $past(q.reg_a) && q.pending_flag_a && q.next_is_b;
  endproperty
  a_pwm_order: assert property (p_pwm_order)
    else $error("PWM reload order wrong");

  property p_stopped;
    @(posedge clk_i) disable iff (rst_i)
    !cap_mode && !q.run_or_underflow_bit && !wr_cnt |=> $stable(q.count);
  endproperty
  a_stopped: assert property (p_stopped)
    else $error("stopped timer moved");

  property p_event_count;
    @(posedge clk_i) disable iff (rst_i)
    evt_mode && q.run_or_underflow_bit && a_rise && !q.mode_sel_bit1
      && q.count != CNT_ZERO && !wr_cnt
      |=> q.count == $past(q.count) - CNT_ONE;
  endproperty
  a_event_count: assert property (p_event_count)
    else $error("event edge not counted");

  property p_irq_a;
    @(posedge clk_i) disable iff (rst_i)
    !q.irq_enable_a |=> !irq_a_o;
  endproperty
  a_irq_a: assert property (p_irq_a)
    else $error("A request while disabled");

  property p_irq_a_uf;
    @(posedge clk_i) disable iff (rst_i)
    q.irq_enable_a && cap_mode && q.run_or_underflow_bit |=> irq_a_o;
  endproperty
  a_irq_a_uf: assert property (p_irq_a_uf)
    else $error("underflow request missing");

  property p_irq_b;
    @(posedge clk_i) disable iff (rst_i)
    q.irq_enable_b && q.pending_flag_b |=> irq_b_o;
  endproperty
  a_irq_b: assert property (p_irq_b)
    else $error("B request missing");

  property p_set_wins;
    @(posedge clk_i) disable iff (rst_i)
    set_a |=> q.pending_flag_a ##1 (q.pending_flag_a || $past(wr_ctrl));
  endproperty
  a_set_wins: assert property (p_set_wins)
    else $error("flag A set was lost");

  property p_pwm_order_b;
    @(posedge clk_i) disable iff (rst_i)
    pwm_mode && uflow && q.next_is_b && !wr_cnt
      |=> q.count == $past(q.reg_b) && q.pending_flag_b && !q.next_is_b;
  endproperty
  a_pwm_order_b: assert property (p_pwm_order_b)
    else $error("PWM reload from B wrong");

  property p_pwm_toggle;
    @(posedge clk_i) disable iff (rst_i)
    pwm_mode && uflow && q.mode_sel_bit1
      |=> timer_pin_a_o != $past(timer_pin_a_o);
  endproperty
  a_pwm_toggle: assert property (p_pwm_toggle)
    else $error("PWM pin did not toggle");

  property p_event_b;
    @(posedge clk_i) disable iff (rst_i)
    evt_mode && b_rise |=> q.pending_flag_b;
  endproperty
  a_event_b: assert property (p_event_b)
    else $error("pin B rise not flagged");

  property p_event_no_drive;
    @(posedge clk_i) disable iff (rst_i)
    evt_mode |=> !timer_pin_a_oe_o;
  endproperty
  a_event_no_drive: assert property (p_event_no_drive)
    else $error("pin A driven in event mode");
endmodule

// ==== design/cpet_pkg.sv ====
// Constants and layouts of the capture, PWM and event timer
// What this block does
// - capture edge copies timer count into register
// - pin A loads register A, pin B register B
// - edge polarity chosen separately per pin
// - capture edges: bit1 for A, bit3 for B
// - mode bits decode event, PWM, capture
// - each pin trigger sets its pending flag
// - enable A gates the A-side request
// - enable B gates the B-side request
// - capture underflow sets run/underflow bit
// - enable A also gates capture underflow request
// - run bit starts or stops PWM/event counting
// - every instance identical, own pins and registers
// - PWM reloads A first, then B, A alternately
// - event mode counts pin A edges, B rising flags
package cpet_pkg;
  localparam int CLK_PERIOD_NS = 20;
  localparam int TC_PERIOD_NS = 1000;
  localparam int TC_DIV = TC_PERIOD_NS / CLK_PERIOD_NS;
  localparam logic [5:0] TC_LAST = 6'(TC_DIV - 1);
  localparam logic [5:0] DIV_ONE = 6'h01;
  localparam logic [15:0] CNT_ONE = 16'h0001;
  localparam logic [15:0] CNT_ZERO = 16'h0000;
  localparam logic [15:0] CNT_WRAP = 16'hFFFF;
  localparam logic [3:0] ADR_CTRL = 4'h0;
  localparam logic [3:0] ADR_COUNT = 4'h4;
  localparam logic [3:0] ADR_REG_A = 4'h8;
  localparam logic [3:0] ADR_REG_B = 4'hC;
  localparam int B_ENB = 0;
  localparam int B_PNDB = 1;
  localparam int B_ENA = 2;
  localparam int B_PNDA = 3;
  localparam int B_RUN = 4;
  localparam int B_M1 = 5;
  localparam int B_M2 = 6;
  localparam int B_M3 = 7;
endpackage

// ==== design/cpet_pin_sync.sv ====
// Three-stage pin synchroniser with agreed-level edge pulses
`timescale 1ns/100ps
module cpet_pin_sync
  import cpet_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic pin_i,
  output logic rise_o,
  output logic fall_o
);
  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic lvl;
    logic rise;
    logic fall;
    logic v1;
    logic v2;
    logic v3;
    logic armed;
  } cpet_sync_s;

  cpet_sync_s q, d;

  always_comb begin
    d = q;
    d.s1 = pin_i;
    d.s2 = q.s1;
    d.s3 = q.s2;
    d.rise = 1'b0;
    d.fall = 1'b0;
    d.v1 = 1'b1;
    d.v2 = q.v1;
    d.v3 = q.v2;
    // Change counts only once stages two and three agree
    if (q.s2 == q.s3) begin
      if (!q.armed) begin
        // First settled level is no edge: a pin may idle high
        d.lvl = q.s3;
        d.armed = q.v3;
      end else if (q.s3 != q.lvl) begin
        d.lvl = q.s3;
        d.rise = q.s3;
        d.fall = !q.s3;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign rise_o = q.rise;
  assign fall_o = q.fall;
endmodule

// ==== sim/cpet_pin_model.sv ====
// External signal source for the two timer pins
`timescale 1ns/100ps
module cpet_pin_model (
  input wire logic clk_i,
  output logic pin_a_o,
  output logic pin_b_o
);
  initial begin
    pin_a_o = 1'b0;
    pin_b_o = 1'b0;
  end
  // Level held long enough to pass the synchroniser
  task automatic drive(input logic a, input logic b);
    @(posedge clk_i);
    pin_a_o <= a;
    pin_b_o <= b;
    repeat (10) @(posedge clk_i);
  endtask
endmodule

// ==== sim/tb.sv ====
// Register-level bench of the capture, PWM and event timer
`timescale 1ns/100ps
module tb;
  import cpet_pkg::*;
  logic clk_i, rst_i, cyc, stb, we, ack, pa_o, pa_oe, irq_a, irq_b;
  logic pm_a, pm_b;
  logic [3:0] adr;
  logic [31:0] wd, rd, q, keep;
  int n_mismatch, checks_done, cycles;
  // Pin A wire: timer drives only while enabled
  wire logic pin_a = pa_oe ? pa_o : pm_a;
  cpet_timer uut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb),
    .we_i(we), .adr_i(adr), .sel_i(4'hF), .dat_i(wd), .dat_o(rd),
    .ack_o(ack), .timer_pin_a_i(pin_a), .timer_pin_a_o(pa_o),
    .timer_pin_a_oe_o(pa_oe), .timer_pin_b_i(pm_b), .irq_a_o(irq_a),
    .irq_b_o(irq_b));
  cpet_pin_model pm (.clk_i(clk_i), .pin_a_o(pm_a), .pin_b_o(pm_b));
  task automatic print_verdict();
    $display("mismatches %0d checks %0d", n_mismatch, checks_done);
    if (n_mismatch == 0 && checks_done > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wd <= d;
    do @(posedge clk_i); while (ack !== 1'b1);
    q = rd;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  // Near allows one tick of the free count to slip in
  task automatic chk(input string s, input logic [31:0] e,
                     input logic [31:0] g, input bit near);
    checks_done++;
    if (!(g === e || (near && g === e - 32'h1))) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", s, e, g);
    end
  endtask
  task automatic rdc(input logic [3:0] a, input logic [31:0] e, input bit n);
    wb(1'b0, a, 32'h0);
    chk("register", e, q, n);
  endtask
  always @(posedge clk_i) begin
    cycles++;
    if (cycles > 4000) begin
      n_mismatch++;
      print_verdict();
    end
  end
  initial begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end
  initial begin
    rst_i = 1'b1;
    {cyc, stb, we, adr, wd} = '0;
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    rdc(ADR_CTRL, 32'h0, 0);
    // Capture: A rising, B falling, both enables, run clear
    wb(1'b1, ADR_CTRL, 32'hC5);
    wb(1'b1, ADR_COUNT, 32'h1000);
    pm.drive(1'b1, 1'b0);
    pm.drive(1'b1, 1'b1);
    rdc(ADR_CTRL, 32'hCD, 0);
    pm.drive(1'b1, 1'b0);
    rdc(ADR_REG_B, 32'h1000, 1);
    rdc(ADR_REG_A, 32'h1000, 1);
    rdc(ADR_CTRL, 32'hCF, 0);
    chk("irq_a", 32'h1, {31'h0, irq_a}, 0);
    chk("irq_b", 32'h1, {31'h0, irq_b}, 0);
    wb(1'b1, ADR_CTRL, 32'hC6);
    rdc(ADR_CTRL, 32'hC6, 0);
    chk("irq_a", 32'h0, {31'h0, irq_a}, 0);
    chk("irq_b", 32'h0, {31'h0, irq_b}, 0);
    // Free count runs through zero
    wb(1'b1, ADR_CTRL, 32'hC4);
    wb(1'b1, ADR_COUNT, 32'h1);
    repeat (110) @(posedge clk_i);
    rdc(ADR_COUNT, 32'hFFFF, 1);
    rdc(ADR_CTRL, 32'hD4, 0);
    chk("irq_a", 32'h1, {31'h0, irq_a}, 0);
    wb(1'b1, ADR_CTRL, 32'hC0);
    repeat (2) @(posedge clk_i);
    chk("irq_a", 32'h0, {31'h0, irq_a}, 0);
    // PWM with toggle: first reload A, then B
    wb(1'b1, ADR_REG_A, 32'h5);
    wb(1'b1, ADR_REG_B, 32'h9);
    wb(1'b1, ADR_COUNT, 32'h1);
    wb(1'b1, ADR_CTRL, 32'hB0);
    repeat (150) @(posedge clk_i);
    rdc(ADR_CTRL, 32'hB8, 0);
    chk("oe", 32'h1, {31'h0, pa_oe}, 0);
    chk("pin_a", 32'h1, {31'h0, pa_o}, 0);
    repeat (400) @(posedge clk_i);
    rdc(ADR_CTRL, 32'hBA, 0);
    chk("pin_a", 32'h0, {31'h0, pa_o}, 0);
    wb(1'b1, ADR_CTRL, 32'h8A);
    wb(1'b0, ADR_COUNT, 32'h0);
    keep = q;
    repeat (200) @(posedge clk_i);
    chk("oe", 32'h0, {31'h0, pa_oe}, 0);
    rdc(ADR_COUNT, keep, 0);
    // Event counting, rising then falling edge of pin A
    wb(1'b1, ADR_CTRL, 32'h10);
    wb(1'b1, ADR_COUNT, 32'h5);
    pm.drive(1'b0, 1'b0);
    pm.drive(1'b1, 1'b0);
    pm.drive(1'b0, 1'b0);
    pm.drive(1'b1, 1'b1);
    rdc(ADR_COUNT, 32'h3, 0);
    rdc(ADR_CTRL, 32'h12, 0);
    chk("oe", 32'h0, {31'h0, pa_oe}, 0);
    wb(1'b1, ADR_CTRL, 32'h30);
    pm.drive(1'b0, 1'b1);
    rdc(ADR_COUNT, 32'h2, 0);
    // Capture on falling pin A edge only
    wb(1'b1, ADR_COUNT, 32'h100);
    wb(1'b1, ADR_CTRL, 32'hE4);
    pm.drive(1'b1, 1'b1);
    rdc(ADR_CTRL, 32'hE4, 0);
    pm.drive(1'b0, 1'b1);
    rdc(ADR_CTRL, 32'hEC, 0);
    rdc(ADR_REG_A, 32'h100, 1);
    print_verdict();
  end
endmodule
